// ==== src/rot_sub_ret_exec.sv ====
// Execution of return-from-interrupt, accumulator rotates, bit set,
// short jump and subtract-with-borrow.
// Assumes the fetch stage supplies the opcode, second byte and fetched source
// operand, and holds an instruction until ready_o is high.
`timescale 1ns/1ps

module rot_sub_ret_exec (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  // Instruction from fetch
  input  wire exec_pkg::instr_type     instr_i,
  output logic                         ready_o,
  output logic                         done_o,
  // Stack writes from the rest of the core
  input  wire logic                    stack_wr_en_i,
  input  wire logic [7:0]              stack_wr_addr_i,
  input  wire logic [7:0]              stack_wr_data_i,
  // Interrupt controller link
  input  wire logic [1:0]              isr_level_i,
  output logic                         irq_release_o,
  output logic [1:0]                   irq_release_level_o,
  output logic                         irq_hold_o,
  // Bit-addressable space
  output logic                         bit_set_o,
  output logic [7:0]                   bit_addr_o,
  // Architectural state
  output logic [7:0]                   acc_o,
  output exec_pkg::flag_word_type      flags_o,
  output logic [15:0]                  pc_o,
  output logic [7:0]                   sp_o
);

  exec_pkg::state_type     state_reg;
  logic [7:0]              acc_reg;
  exec_pkg::flag_word_type flags_reg;
  logic [15:0]             pc_reg;
  logic [7:0]              sp_reg;
  logic [7:0]              rel_reg;
  logic                    release_reg;
  logic [1:0]              release_level_reg;
  logic                    hold_reg;
  logic                    bit_set_reg;
  logic [7:0]              bit_addr_reg;
  logic [7:0]              pop_hi;
  logic [7:0]              pop_lo;
  logic                    fire;
  logic                    is_subtract_with_borrow;
  logic [7:0]              op;
  logic [8:0]              diff9;
  logic [4:0]              diff_lo;
  logic [7:0]              diff_b7;

  //////////////////////////////////////////////////////////////////////////////
  // Decode

  assign op      = instr_i.opcode;
  assign ready_o = (state_reg == exec_pkg::ST_IDLE);
  assign fire    = ready_o && instr_i.valid;
  // Register, direct, indirect and immediate sources
  assign is_subtract_with_borrow = (op[7:3] == exec_pkg::OP_SUBTRACT_WITH_BORROW_REGISTER_HI)
                || (op[7:1] == exec_pkg::OP_SUBTRACT_WITH_BORROW_INDIRECT_HI)
                || (op == exec_pkg::OP_SUBTRACT_WITH_BORROW_DIRECT)
                || (op == exec_pkg::OP_SUBTRACT_WITH_BORROW_IMMEDIATE);
  // Completion in the last cycle of each instruction
  assign done_o  = (fire && op != exec_pkg::OP_RETURN_FROM_INTERRUPT
                         && op != exec_pkg::OP_SHORT_JUMP)
                || (state_reg != exec_pkg::ST_IDLE);

  //////////////////////////////////////////////////////////////////////////////
  // Subtract with borrow arithmetic

  // Borrow out of bit 7
  assign diff9   = {1'b0, acc_reg} - {1'b0, instr_i.src_data}
                 - {8'h00, flags_reg.cy};
  // Borrow out of bit 3
  assign diff_lo = {1'b0, acc_reg[3:0]} - {1'b0, instr_i.src_data[3:0]}
                 - {4'h0, flags_reg.cy};
  // Borrow into bit 7
  assign diff_b7 = {1'b0, acc_reg[6:0]} - {1'b0, instr_i.src_data[6:0]}
                 - {7'h00, flags_reg.cy};

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer for the two-cycle instructions

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= exec_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        exec_pkg::ST_IDLE: begin
          if (fire && op == exec_pkg::OP_RETURN_FROM_INTERRUPT) begin
            state_reg <= exec_pkg::ST_RETI2;
          end else if (fire && op == exec_pkg::OP_SHORT_JUMP) begin
            state_reg <= exec_pkg::ST_JUMP2;
          end
        end
        exec_pkg::ST_RETI2: state_reg <= exec_pkg::ST_IDLE;
        exec_pkg::ST_JUMP2: state_reg <= exec_pkg::ST_IDLE;
        default:            state_reg <= exec_pkg::ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Accumulator

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      acc_reg <= exec_pkg::ACC_RESET;
    end else if (fire) begin
      case (op)
        exec_pkg::OP_ROTATE_LEFT:
          acc_reg <= {acc_reg[6:0], acc_reg[7]};
        exec_pkg::OP_ROTATE_LEFT_CARRY:
          acc_reg <= {acc_reg[6:0], flags_reg.cy};
        exec_pkg::OP_ROTATE_RIGHT:
          acc_reg <= {acc_reg[0], acc_reg[7:1]};
        exec_pkg::OP_ROTATE_RIGHT_CARRY:
          acc_reg <= {flags_reg.cy, acc_reg[7:1]};
        default: begin
          if (is_subtract_with_borrow) begin
            acc_reg <= diff9[7:0];
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flag word; return-from-interrupt leaves it alone

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flags_reg <= '0;
    end else if (fire) begin
      case (op)
        exec_pkg::OP_ROTATE_LEFT_CARRY:
          flags_reg.cy <= acc_reg[7];
        exec_pkg::OP_ROTATE_RIGHT_CARRY:
          flags_reg.cy <= acc_reg[0];
        exec_pkg::OP_SET_CARRY:
          flags_reg.cy <= 1'b1;
        default: begin
          if (is_subtract_with_borrow) begin
            flags_reg.cy <= diff9[8];
            flags_reg.ac <= diff_lo[4];
            flags_reg.ov <= diff_b7[7] ^ diff9[8];
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Program counter

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pc_reg  <= exec_pkg::PC_RESET;
      rel_reg <= 8'h00;
    end else if (state_reg == exec_pkg::ST_RETI2) begin
      pc_reg <= {pop_hi, pop_lo};
    end else if (state_reg == exec_pkg::ST_JUMP2) begin
      // Signed displacement spans -128..+127 from the next instruction
      pc_reg <= pc_reg + {{8{rel_reg[7]}}, rel_reg};
    end else if (fire) begin
      if (op == exec_pkg::OP_SHORT_JUMP) begin
        pc_reg  <= pc_reg + exec_pkg::LEN_TWO;
        rel_reg <= instr_i.operand;
      end else if (op == exec_pkg::OP_BIT_SET || op == exec_pkg::OP_SUBTRACT_WITH_BORROW_DIRECT
                   || op == exec_pkg::OP_SUBTRACT_WITH_BORROW_IMMEDIATE) begin
        pc_reg <= pc_reg + exec_pkg::LEN_TWO;
      end else if (op != exec_pkg::OP_RETURN_FROM_INTERRUPT) begin
        pc_reg <= pc_reg + exec_pkg::LEN_ONE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Stack pointer, one decrement per popped byte, two per return

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sp_reg <= exec_pkg::SP_RESET;
    end else if ((fire && op == exec_pkg::OP_RETURN_FROM_INTERRUPT)
                 || state_reg == exec_pkg::ST_RETI2) begin
      sp_reg <= sp_reg - 8'h01;
    end
  end

  // Both stack bytes read at once so the pop fits two cycles
  stack_ram #(
    .AW (8)
  ) u_stack (
    .clk_i       (clk_i),
    .wr_en_i     (stack_wr_en_i),
    .wr_addr_i   (stack_wr_addr_i),
    .wr_data_i   (stack_wr_data_i),
    .rd_a_addr_i (sp_reg),
    .rd_b_addr_i (sp_reg - 8'h01),
    .rd_a_data_o (pop_hi),
    .rd_b_data_o (pop_lo)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt priority release and one-instruction hold-off

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      release_reg       <= 1'b0;
      release_level_reg <= 2'b00;
    end else begin
      release_reg <= (state_reg == exec_pkg::ST_RETI2);
      if (fire && op == exec_pkg::OP_RETURN_FROM_INTERRUPT) begin
        release_level_reg <= isr_level_i;
      end
    end
  end

  // Set on return wins over clear by a completing instruction
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hold_reg <= 1'b0;
    end else if (state_reg == exec_pkg::ST_RETI2) begin
      hold_reg <= 1'b1;
    end else if (done_o) begin
      hold_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bit set towards the bit-addressable space

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bit_set_reg  <= 1'b0;
      bit_addr_reg <= 8'h00;
    end else begin
      bit_set_reg <= fire && op == exec_pkg::OP_BIT_SET;
      if (fire && op == exec_pkg::OP_BIT_SET) begin
        bit_addr_reg <= instr_i.operand;
      end
    end
  end

  // Outputs
  assign acc_o               = acc_reg;
  assign flags_o             = flags_reg;
  assign pc_o                = pc_reg;
  assign sp_o                = sp_reg;
  assign irq_release_o       = release_reg;
  assign irq_release_level_o = release_level_reg;
  assign irq_hold_o          = hold_reg;
  assign bit_set_o           = bit_set_reg;
  assign bit_addr_o          = bit_addr_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  return_from_interrupt_pop_a: assert property (
    fire && op == exec_pkg::OP_RETURN_FROM_INTERRUPT |=> (done_o && !ready_o) ##1
      (sp_reg == $past(sp_reg, 2) - 8'h02 && ready_o))
    else $error("return pop did not lower stack pointer by two");

  return_from_interrupt_flags_a: assert property (
    fire && op == exec_pkg::OP_RETURN_FROM_INTERRUPT |=> ##1
      (flags_reg == $past(flags_reg, 2) && acc_reg == $past(acc_reg, 2)))
    else $error("return changed accumulator or flags");

  return_from_interrupt_release_a: assert property (
    fire && op == exec_pkg::OP_RETURN_FROM_INTERRUPT |-> ##2
      (irq_release_o && irq_release_level_o == $past(isr_level_i, 2)))
    else $error("priority level not released after return");

  return_from_interrupt_hold_a: assert property (
    (state_reg == exec_pkg::ST_RETI2) || (irq_hold_o && !done_o) |=> irq_hold_o)
    else $error("hold-off dropped before next instruction");

  hold_clear_a: assert property (
    irq_hold_o && done_o && state_reg != exec_pkg::ST_RETI2 |=> !irq_hold_o)
    else $error("hold-off kept after the next instruction");

  rot_left_a: assert property (
    fire && op == exec_pkg::OP_ROTATE_LEFT |=>
      acc_reg == {$past(acc_reg[6:0]), $past(acc_reg[7])} && $stable(flags_reg))
    else $error("rotate left wrong");

  rot_carry_a: assert property (
    fire && op == exec_pkg::OP_ROTATE_LEFT_CARRY |=>
      {flags_reg.cy, acc_reg} == {$past(acc_reg), $past(flags_reg.cy)})
    else $error("rotate left through carry wrong");

  rot_right_a: assert property (
    fire && op == exec_pkg::OP_ROTATE_RIGHT_CARRY |=>
      {acc_reg, flags_reg.cy} == {$past(flags_reg.cy), $past(acc_reg)})
    else $error("rotate right through carry wrong");

  jump_target_a: assert property (
    fire && op == exec_pkg::OP_SHORT_JUMP |-> ##2
      pc_reg == $past(pc_reg, 2) + 16'h0002 + {{8{$past(instr_i.operand[7], 2)}},
                                               $past(instr_i.operand, 2)})
    else $error("short jump target wrong");

  subtract_with_borrow_result_a: assert property (
    fire && is_subtract_with_borrow |=> {flags_reg.cy, acc_reg} ==
      ({1'b0, $past(acc_reg)} - {1'b0, $past(instr_i.src_data)}
       - {8'h00, $past(flags_reg.cy)}))
    else $error("subtract result or borrow wrong");

  subtract_with_borrow_ov_a: assert property (
    fire && is_subtract_with_borrow && acc_reg[7] != instr_i.src_data[7] |=>
      flags_reg.ov == (acc_reg[7] != $past(acc_reg[7])))
    else $error("overflow flag wrong");

  cover_return_from_interrupt_c:  cover property (state_reg == exec_pkg::ST_RETI2 ##1 done_o);
  cover_jump_c:  cover property (fire && op == exec_pkg::OP_SHORT_JUMP
                                 && instr_i.operand[7]);
  cover_subtract_with_borrow_c:  cover property (fire && is_subtract_with_borrow ##1 flags_reg.ov && flags_reg.ac);
  cover_bit_set_c:  cover property (bit_set_o);

endmodule

// ==== src/exec_pkg.sv ====
// Constants, opcodes and carrier types for the rotate, subtract and return unit.
// Assumes an 8-bit core with one machine cycle per clock and 256-byte internal RAM.

package exec_pkg;

  // Opcodes
  localparam logic [7:0] OP_RETURN_FROM_INTERRUPT = 8'h32;
  localparam logic [7:0] OP_ROTATE_LEFT           = 8'h23;
  localparam logic [7:0] OP_ROTATE_LEFT_CARRY     = 8'h33;
  localparam logic [7:0] OP_ROTATE_RIGHT          = 8'h03;
  localparam logic [7:0] OP_ROTATE_RIGHT_CARRY    = 8'h13;
  localparam logic [7:0] OP_SET_CARRY             = 8'hD3;
  localparam logic [7:0] OP_BIT_SET               = 8'hD2;
  localparam logic [7:0] OP_SHORT_JUMP            = 8'h80;
  localparam logic [7:0] OP_SUBTRACT_WITH_BORROW_IMMEDIATE        = 8'h94;
  localparam logic [7:0] OP_SUBTRACT_WITH_BORROW_DIRECT           = 8'h95;
  localparam logic [6:0] OP_SUBTRACT_WITH_BORROW_INDIRECT_HI      = 7'h4B;
  localparam logic [4:0] OP_SUBTRACT_WITH_BORROW_REGISTER_HI      = 5'h13;

  // Instruction lengths and reset values
  localparam logic [15:0] LEN_ONE    = 16'h0001;
  localparam logic [15:0] LEN_TWO    = 16'h0002;
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [7:0]  SP_RESET   = 8'h07;
  localparam logic [7:0]  ACC_RESET  = 8'h00;
  localparam int          MULTI_CYCLES = 2;

  // Flag word bit positions
  localparam int FLAG_CY_POS = 7;
  localparam int FLAG_AC_POS = 6;
  localparam int FLAG_OV_POS = 2;

  // One instruction offered by the fetch stage
  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
    logic [7:0] operand;
    logic [7:0] src_data;
  } instr_type;

  // Processor flag word
  typedef struct packed {
    logic       cy;
    logic       ac;
    logic [2:0] other_hi;
    logic       ov;
    logic [1:0] other_lo;
  } flag_word_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RETI2 = 3'b010,
    ST_JUMP2 = 3'b100
  } state_type;

endpackage

// ==== src/stack_ram.sv ====
// Internal RAM holding the stack: one write port, two registered read ports.
// Assumes the core resolves write and read to the same address itself.
`timescale 1ns/1ps

module stack_ram #(
  parameter int AW = 8
) (
  // Clock
  input  wire logic          clk_i,
  // Write port
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [7:0]    wr_data_i,
  // Read ports
  input  wire logic [AW-1:0] rd_a_addr_i,
  input  wire logic [AW-1:0] rd_b_addr_i,
  output logic      [7:0]    rd_a_data_o,
  output logic      [7:0]    rd_b_data_o
);

  logic [7:0] mem [2**AW];

  // Byte storage
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered read data
  always_ff @(posedge clk_i) begin
    rd_a_data_o <= mem[rd_a_addr_i];
    rd_b_data_o <= mem[rd_b_addr_i];
  end

endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the rotate, subtract and return unit.
// Assumes exec_pkg and rot_sub_ret_exec are compiled first; the bench drives every input.
`timescale 1ns/1ps

module tb;
  ////////////////////////////////////////////////////////////////////////////////////////////
  // Design inputs and outputs
  logic                    clk_i;
  logic                    sys_rst_i;
  exec_pkg::instr_type     instr_i;
  logic                    stack_wr_en_i;
  logic [7:0]              stack_wr_addr_i;
  logic [7:0]              stack_wr_data_i;
  logic [1:0]              isr_level_i;
  logic                    ready_o;
  logic                    done_o;
  logic                    irq_release_o;
  logic [1:0]              irq_release_level_o;
  logic                    irq_hold_o;
  logic                    bit_set_o;
  logic [7:0]              bit_addr_o;
  logic [7:0]              acc_o;
  exec_pkg::flag_word_type flags_o;
  logic [15:0]             pc_o;
  logic [7:0]              sp_o;
  // Bench model of the architectural state
  logic [7:0]              m_acc;
  logic [7:0]              m_sp;
  logic [15:0]             m_pc;
  logic                    m_cy;
  logic                    m_ac;
  logic                    m_ov;
  logic [7:0]              m_ram [256];
  integer                  seed;
  integer                  err_total;
  integer                  num_checks;
  logic [7:0]              op_tab [20] = '{8'h23, 8'h33, 8'h03, 8'h13, 8'hD3, 8'hD2, 8'h80,
                                           8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'h99, 8'h9A,
                                           8'h9B, 8'h9C, 8'h9D, 8'h9E, 8'h9F, 8'hA5};

  rot_sub_ret_exec rot_sub_ret_exec_i (
    .clk_i               (clk_i),
    .sys_rst_i           (sys_rst_i),
    .instr_i             (instr_i),
    .ready_o             (ready_o),
    .done_o              (done_o),
    .stack_wr_en_i       (stack_wr_en_i),
    .stack_wr_addr_i     (stack_wr_addr_i),
    .stack_wr_data_i     (stack_wr_data_i),
    .isr_level_i         (isr_level_i),
    .irq_release_o       (irq_release_o),
    .irq_release_level_o (irq_release_level_o),
    .irq_hold_o          (irq_hold_o),
    .bit_set_o           (bit_set_o),
    .bit_addr_o          (bit_addr_o),
    .acc_o               (acc_o),
    .flags_o             (flags_o),
    .pc_o                (pc_o),
    .sp_o                (sp_o)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Clock at 4 ns period
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Compare one value and count the outcome
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Print counts and the verdict, then stop
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Subtract with borrow: returns {cy, ac, ov, acc}
  function automatic logic [10:0] subtract_with_borrow_exp(input logic [7:0] a, input logic [7:0] s,
                                           input logic c);
    logic [8:0] d9;
    logic [4:0] d4;
    logic [7:0] d7;
    d9 = {1'b0, a} - {1'b0, s} - {8'h00, c};
    d4 = {1'b0, a[3:0]} - {1'b0, s[3:0]} - {4'h0, c};
    d7 = {1'b0, a[6:0]} - {1'b0, s[6:0]} - {7'h00, c};
    return {d9[8], d4[4], d7[7] ^ d9[8], d9[7:0]};
  endfunction

  // Compare accumulator, flags, PC and stack pointer with the model
  task automatic check_state();
    check({8'h00, acc_o}, {8'h00, m_acc});
    check({8'h00, flags_o}, {8'h00, m_cy, m_ac, 3'b000, m_ov, 2'b00});
    check(pc_o, m_pc);
    check({8'h00, sp_o}, {8'h00, m_sp});
  endtask

  // Push one byte into the stack RAM with the instruction port idle
  task automatic write_stack(input logic [7:0] a, input logic [7:0] d);
    instr_i.valid = 1'b0;
    stack_wr_en_i = 1'b1;
    stack_wr_addr_i = a;
    stack_wr_data_i = d;
    m_ram[a] = d;
    @(negedge clk_i);
    stack_wr_en_i = 1'b0;
  endtask

  // Offer one instruction at a falling edge; it stays offered after the task returns
  task automatic issue(input logic [7:0] op, input logic [7:0] opnd, input logic [7:0] src);
    logic        two;
    logic [10:0] r;
    logic [15:0] pc0;
    logic [7:0]  sp0;
    two = (op == exec_pkg::OP_RETURN_FROM_INTERRUPT) || (op == exec_pkg::OP_SHORT_JUMP);
    pc0 = m_pc;
    sp0 = m_sp;
    instr_i = {1'b1, op, opnd, src};
    #1;
    check({15'h0000, ready_o}, 16'h0001);
    check({15'h0000, done_o}, {15'h0000, !two});
    @(posedge clk_i);
    r = subtract_with_borrow_exp(m_acc, src, m_cy);
    m_pc = m_pc + 16'h0001;
    case (op)
      8'h32: begin
        m_pc = {m_ram[m_sp], m_ram[m_sp - 8'h01]};
        m_sp = m_sp - 8'h02;
      end
      8'h23: m_acc = {m_acc[6:0], m_acc[7]};
      8'h33: {m_cy, m_acc} = {m_acc, m_cy};
      8'h03: m_acc = {m_acc[0], m_acc[7:1]};
      8'h13: {m_acc, m_cy} = {m_cy, m_acc};
      8'hD3: m_cy = 1'b1;
      8'hD2: m_pc = pc0 + 16'h0002;
      8'h80: m_pc = pc0 + 16'h0002 + {{8{opnd[7]}}, opnd};
      8'h94, 8'h95: begin
        {m_cy, m_ac, m_ov, m_acc} = r;
        m_pc = pc0 + 16'h0002;
      end
      8'h96, 8'h97, 8'h98, 8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h9E, 8'h9F: begin
        {m_cy, m_ac, m_ov, m_acc} = r;
      end
      default: ;
    endcase
    @(negedge clk_i);
    if (two) begin
      // Second cycle: the held offer must be refused
      check({15'h0000, done_o}, 16'h0001);
      check({15'h0000, ready_o}, 16'h0000);
      if (op == exec_pkg::OP_SHORT_JUMP) begin
        check(pc_o, pc0 + 16'h0002);
      end else begin
        check({8'h00, sp_o}, {8'h00, sp0 - 8'h01});
      end
      @(negedge clk_i);
    end
    check({15'h0000, bit_set_o}, {15'h0000, op == 8'hD2});
    if (op == 8'hD2) begin
      check({8'h00, bit_addr_o}, {8'h00, opnd});
    end
    check_state();
  endtask

  // Return with a given level, then one instruction before the hold drops
  task automatic do_return(input logic [1:0] lvl, input logic idle_gap);
    write_stack(m_sp, 8'($random(seed)));
    write_stack(m_sp - 8'h01, 8'($random(seed)));
    isr_level_i = lvl;
    issue(exec_pkg::OP_RETURN_FROM_INTERRUPT, 8'h00, 8'h00);
    check({15'h0000, irq_release_o}, 16'h0001);
    check({14'h0000, irq_release_level_o}, {14'h0000, lvl});
    check({15'h0000, irq_hold_o}, 16'h0001);
    isr_level_i = 2'($random(seed));
    if (idle_gap) begin
      instr_i.valid = 1'b0;
      repeat (3) @(negedge clk_i);
      check({15'h0000, irq_hold_o}, 16'h0001);
      check({15'h0000, irq_release_o}, 16'h0000);
    end
    issue(op_tab[{$random(seed)} % 19], 8'($random(seed)), 8'($random(seed)));
    check({15'h0000, irq_hold_o}, 16'h0000);
    check({15'h0000, irq_release_o}, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total = err_total + 1;
    $display("ERROR at %0t: watchdog expired", $time);
    give_verdict();
  end

  // Main sequence
  initial begin
    seed = 91322;
    err_total = 0;
    num_checks = 0;
    sys_rst_i = 1'b1;
    instr_i = '0;
    stack_wr_en_i = 1'b0;
    stack_wr_addr_i = 8'h00;
    stack_wr_data_i = 8'h00;
    isr_level_i = 2'h0;
    {m_acc, m_cy, m_ac, m_ov, m_pc, m_sp} = {8'h00, 3'b000, 16'h0000, 8'h07};
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
    check({15'h0000, ready_o}, 16'h0001);
    check_state();
    // Worked subtract: C9 minus 54 with carry set gives 74, overflow only
    issue(8'h94, 8'h37, 8'h37);
    issue(8'h9A, 8'h00, 8'h54);
    check({8'h00, acc_o}, 16'h0074);
    check({8'h00, flags_o}, 16'h0004);
    // Every rotate, the carry set and a bit set, with carry set before both rotates through carry
    issue(8'hD3, 8'h00, 8'h00);
    issue(8'h23, 8'h00, 8'h00);
    issue(8'h33, 8'h00, 8'h00);
    issue(8'h03, 8'h00, 8'h00);
    issue(8'h13, 8'h00, 8'h00);
    issue(8'hD2, 8'hA7, 8'h00);
    // Jump displacement extremes, back to back
    issue(8'h80, 8'h7F, 8'h00);
    issue(8'h80, 8'h80, 8'h00);
    issue(8'h80, 8'hFE, 8'h00);
    issue(8'h80, 8'h00, 8'h00);
    // Returns at all four levels, with and without an idle gap
    for (int i = 0; i < 4; i++) begin
      do_return(i[1:0], i[0]);
    end
    // Random mix of every opcode including returns
    for (int i = 0; i < 400; i++) begin
      if ({$random(seed)} % 10 == 0) begin
        do_return(2'($random(seed)), 1'($random(seed)));
      end else begin
        issue(op_tab[{$random(seed)} % 20], 8'($random(seed)), 8'($random(seed)));
      end
    end
    instr_i.valid = 1'b0;
    @(negedge clk_i);
    give_verdict();
  end
endmodule
